// ==== core/dcp_pkg.sv ====
// What this block does
// - Read-only 16-bit source progress pointer, index of current source byte.
// - In pattern detect mode a match zeroes source and cell progress pointers.
// - Read-only 16-bit destination progress pointer, index of current destination byte.
// - Each trigger moves cell_bytes bytes; zero means 65,536 bytes.
// - Read-only 16-bit cell progress counts bytes moved since last trigger.
// - Match value compared against data only in pattern detect and pattern terminate modes.
// - Bits 31-16 of pointer, cell and pattern registers read zero, ignore writes.
// - Match in pattern terminate mode with match_abort_enable set aborts transfer and clears channel_on.
// - cell_done_flag sets when cell_bytes bytes have moved.
// - block_done_flag sets when larger length moved or on pattern match.
package dcp_pkg;
	localparam int DCP_W = 16;
	localparam logic [7:0] DCP_OFS_SRC_PROG = 8'h00;
	localparam logic [7:0] DCP_OFS_DST_PROG = 8'h04;
	localparam logic [7:0] DCP_OFS_CELL_BYTES = 8'h08;
	localparam logic [7:0] DCP_OFS_CELL_PROG = 8'h0C;
	localparam logic [7:0] DCP_OFS_MATCH = 8'h10;
	localparam logic [7:0] DCP_OFS_CTRL = 8'h14;
	localparam logic [7:0] DCP_OFS_SRC_LEN = 8'h18;
	localparam logic [7:0] DCP_OFS_DST_LEN = 8'h1C;
	localparam logic [7:0] DCP_OFS_STAT = 8'h20;
	localparam logic [7:0] DCP_OFS_MASK = 8'h24;
	localparam int DCP_CTRL_ON = 0;
	localparam int DCP_CTRL_ABT = 1;
	localparam int DCP_CTRL_MODE = 2;
	localparam int DCP_ST_CELL = 0;
	localparam int DCP_ST_BLOCK = 1;
	localparam int DCP_ST_ABORT = 2;
	localparam int DCP_NSTAT = 3;
	localparam logic [16:0] DCP_FULL = 17'h10000;
	localparam logic [15:0] DCP_ZERO16 = 16'h0000;
	localparam logic [31:0] DCP_ZERO32 = 32'h00000000;
	localparam logic [1:0] DCP_HTRANS_NONSEQ = 2'h2;
	// Match modes for the channel
	typedef enum logic [1:0] {
		DCP_MODE_NONE = 2'h0,
		DCP_MODE_DETECT = 2'h1,
		DCP_MODE_TERM = 2'h3
	} dcp_mode_t;
	typedef enum logic [1:0] {
		DCP_BUS_IDLE = 2'h0,
		DCP_BUS_WR = 2'h1,
		DCP_BUS_RD = 2'h3
	} dcp_bus_t;
	// Size field of zero stands for the full 65,536
	function automatic logic [16:0] dcp_len(input logic [15:0] v);
		dcp_len = (v == DCP_ZERO16) ? DCP_FULL : {1'b0, v};
	endfunction
endpackage

// ==== core/dcp_ptr.sv ====
`timescale 1ns/10ps
// One progress pointer with wrap at region end
module dcp_ptr
	import dcp_pkg::*;
#(
	parameter int W = 16
) (
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Control
	input wire logic clr,
	input wire logic step,
	input wire logic [2:0] amount,
	input wire logic [W:0] limit,
	// State
	output logic [W-1:0] value,
	output logic wrapped
);
	logic [W-1:0] val_r, val_nxt;
	logic [W:0] sum;
	always_comb begin
		sum = {1'b0, val_r} + {{(W-2){1'b0}}, amount};
		val_nxt = val_r;
		wrapped = 1'b0;
		if (clr) begin
			val_nxt = '0;
		end else if (step) begin
			if (sum >= limit) begin
				val_nxt = '0;
				wrapped = 1'b1;
			end else begin
				val_nxt = sum[W-1:0];
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			val_r <= '0;
		end else if (ce) begin
			val_r <= val_nxt;
		end
	end
	assign value = val_r;
endmodule // dcp_ptr

// ==== core/dcp_top.sv ====
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module dcp_top
	import dcp_pkg::*;
(
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Transfer engine side
	input wire logic xfer_valid,
	input wire logic [2:0] xfer_bytes,
	input wire logic [15:0] xfer_data,
	input wire logic cell_start,
	// Channel state
	output logic channel_on,
	output logic xfer_abort,
	output logic irq
);
	import dcp_pkg::*;

	logic [15:0] cell_bytes_r, cell_bytes_nxt;
	logic [15:0] match_value_r, match_value_nxt;
	logic [15:0] src_length_r, src_length_nxt;
	logic [15:0] dst_length_r, dst_length_nxt;
	logic [15:0] cell_progress_r, cell_progress_nxt;
	logic [15:0] moved_r, moved_nxt;
	logic channel_on_r, channel_on_nxt;
	logic abt_en_r, abt_en_nxt;
	dcp_mode_t mode_r, mode_nxt;
	logic [DCP_NSTAT-1:0] stat_r, stat_nxt;
	logic [DCP_NSTAT-1:0] mask_r, mask_nxt;
	logic abort_r, abort_nxt;
	logic irq_r, irq_nxt;
	dcp_bus_t ph_r, ph_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [15:0] src_progress, dst_progress;
	logic src_wrap, dst_wrap;
	logic match_hit, ptr_clr, active, cell_hit, block_hit;
	logic [16:0] cell_sum, big_len, moved_sum;
	logic [DCP_NSTAT-1:0] ev;

	assign active = channel_on_r && xfer_valid;
	// compare only in a pattern mode
	assign match_hit = active && (mode_r == DCP_MODE_DETECT || mode_r == DCP_MODE_TERM) &&
		(xfer_data == match_value_r);
	assign ptr_clr = cell_start || (match_hit && mode_r == DCP_MODE_DETECT);

	dcp_ptr #(.W(DCP_W)) u_src (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.clr(ptr_clr),
		.step(active),
		.amount(xfer_bytes),
		.limit(dcp_len(src_length_r)),
		.value(src_progress),
		.wrapped(src_wrap)
	);
	dcp_ptr #(.W(DCP_W)) u_dst (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.clr(cell_start),
		.step(active),
		.amount(xfer_bytes),
		.limit(dcp_len(dst_length_r)),
		.value(dst_progress),
		.wrapped(dst_wrap)
	);

	// Cell and block progress
	always_comb begin
		cell_sum = {1'b0, cell_progress_r} + {14'h0000, xfer_bytes};
		moved_sum = {1'b0, moved_r} + {14'h0000, xfer_bytes};
		big_len = (dcp_len(src_length_r) > dcp_len(dst_length_r)) ?
			dcp_len(src_length_r) : dcp_len(dst_length_r);
		cell_hit = active && (cell_sum >= dcp_len(cell_bytes_r));
		// block end by length or match
		block_hit = (active && moved_sum >= big_len) || match_hit;
		cell_progress_nxt = cell_progress_r;
		moved_nxt = moved_r;
		if (cell_start || cell_hit || ptr_clr) begin
			cell_progress_nxt = DCP_ZERO16;
		end else if (active) begin
			cell_progress_nxt = cell_sum[15:0];
		end
		if (block_hit) begin
			moved_nxt = DCP_ZERO16;
		end else if (active) begin
			moved_nxt = moved_sum[15:0];
		end
	end

	// Bus and register file
	always_comb begin
		logic sel;
		logic [15:0] wd;
		sel = hsel && hready && (htrans == DCP_HTRANS_NONSEQ);
		wd = hwdata[15:0];
		ph_nxt = sel ? (hwrite ? DCP_BUS_WR : DCP_BUS_RD) : DCP_BUS_IDLE;
		addr_nxt = sel ? haddr : addr_r;
		cell_bytes_nxt = cell_bytes_r;
		match_value_nxt = match_value_r;
		src_length_nxt = src_length_r;
		dst_length_nxt = dst_length_r;
		channel_on_nxt = channel_on_r;
		abt_en_nxt = abt_en_r;
		mode_nxt = mode_r;
		mask_nxt = mask_r;
		ev = '0;
		ev[DCP_ST_CELL] = cell_hit;
		ev[DCP_ST_BLOCK] = block_hit;
		ev[DCP_ST_ABORT] = match_hit && abt_en_r && mode_r == DCP_MODE_TERM;
		stat_nxt = stat_r;
		if (ph_r == DCP_BUS_WR) begin
			unique case (addr_r)
				DCP_OFS_CELL_BYTES: cell_bytes_nxt = wd;
				DCP_OFS_MATCH: match_value_nxt = wd;
				DCP_OFS_SRC_LEN: src_length_nxt = wd;
				DCP_OFS_DST_LEN: dst_length_nxt = wd;
				DCP_OFS_CTRL: begin
					channel_on_nxt = wd[DCP_CTRL_ON];
					abt_en_nxt = wd[DCP_CTRL_ABT];
					mode_nxt = dcp_mode_t'(wd[DCP_CTRL_MODE+1:DCP_CTRL_MODE]);
				end
				DCP_OFS_STAT: stat_nxt = stat_r & ~wd[DCP_NSTAT-1:0];
				DCP_OFS_MASK: mask_nxt = wd[DCP_NSTAT-1:0];
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		stat_nxt = stat_nxt | ev;
		abort_nxt = ev[DCP_ST_ABORT];
		if (ev[DCP_ST_ABORT] || block_hit) begin
			channel_on_nxt = 1'b0;
		end
		irq_nxt = |(stat_nxt & mask_nxt);
		rdata_nxt = DCP_ZERO32;
		if (ph_nxt == DCP_BUS_RD) begin
			unique case (haddr)
				DCP_OFS_SRC_PROG: rdata_nxt = {DCP_ZERO16, src_progress};
				DCP_OFS_DST_PROG: rdata_nxt = {DCP_ZERO16, dst_progress};
				DCP_OFS_CELL_BYTES: rdata_nxt = {DCP_ZERO16, cell_bytes_r};
				DCP_OFS_CELL_PROG: rdata_nxt = {DCP_ZERO16, cell_progress_r};
				DCP_OFS_MATCH: rdata_nxt = {DCP_ZERO16, match_value_r};
				DCP_OFS_SRC_LEN: rdata_nxt = {DCP_ZERO16, src_length_r};
				DCP_OFS_DST_LEN: rdata_nxt = {DCP_ZERO16, dst_length_r};
				DCP_OFS_CTRL: rdata_nxt = {28'h0000000, mode_r, abt_en_r, channel_on_r};
				DCP_OFS_STAT: rdata_nxt = {29'h00000000, stat_r};
				DCP_OFS_MASK: rdata_nxt = {29'h00000000, mask_r};
				default: rdata_nxt = DCP_ZERO32;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cell_bytes_r <= '0;
			match_value_r <= '0;
			src_length_r <= '0;
			dst_length_r <= '0;
			cell_progress_r <= '0;
			moved_r <= '0;
			channel_on_r <= 1'b0;
			abt_en_r <= 1'b0;
			mode_r <= DCP_MODE_NONE;
			stat_r <= '0;
			mask_r <= '0;
			abort_r <= 1'b0;
			irq_r <= 1'b0;
			ph_r <= DCP_BUS_IDLE;
			addr_r <= '0;
			rdata_r <= '0;
		end else if (ce) begin
			cell_bytes_r <= cell_bytes_nxt;
			match_value_r <= match_value_nxt;
			src_length_r <= src_length_nxt;
			dst_length_r <= dst_length_nxt;
			cell_progress_r <= cell_progress_nxt;
			moved_r <= moved_nxt;
			channel_on_r <= channel_on_nxt;
			abt_en_r <= abt_en_nxt;
			mode_r <= mode_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			abort_r <= abort_nxt;
			irq_r <= irq_nxt;
			ph_r <= ph_nxt;
			addr_r <= addr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign hrdata = rdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign channel_on = channel_on_r;
	assign xfer_abort = abort_r;
	assign irq = irq_r;

	a_detect_clr: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && match_hit && mode_r == DCP_MODE_DETECT) |=> cell_progress_r == DCP_ZERO16)
		else $error("cell progress not cleared on detect");
	a_abort_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && match_hit && abt_en_r && mode_r == DCP_MODE_TERM) |=> (!channel_on_r && abort_r))
		else $error("match abort did not stop channel");
	a_cell_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && cell_hit) |=> stat_r[DCP_ST_CELL])
		else $error("cell flag not set");
	a_block_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && block_hit) |=> stat_r[DCP_ST_BLOCK])
		else $error("block flag not set");
	a_no_match_none: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && active && mode_r != DCP_MODE_DETECT && mode_r != DCP_MODE_TERM &&
			moved_sum < big_len && ph_r != DCP_BUS_WR) |=> channel_on_r)
		else $error("pattern stopped channel outside pattern modes");
	a_cell_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		{1'b0, cell_progress_r} < dcp_len(cell_bytes_r) || cell_bytes_r == DCP_ZERO16)
		else $error("cell progress past cell size");
	a_src_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		{1'b0, src_progress} < dcp_len(src_length_r) || $changed(src_length_r))
		else $error("source pointer past region");
	a_dst_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && dst_wrap && !cell_start) |=> dst_progress == DCP_ZERO16)
		else $error("destination pointer did not wrap");
	a_top_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(ph_r == DCP_BUS_RD && addr_r == DCP_OFS_CELL_PROG) |->
		hrdata == {DCP_ZERO16, $past(cell_progress_r)})
		else $error("cell progress read back wrong");
	a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && cell_hit && mask_r[DCP_ST_CELL]) |=> irq)
		else $error("cell irq missing");
	a_dst_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		{1'b0, dst_progress} < dcp_len(dst_length_r) || $changed(dst_length_r))
		else $error("destination pointer past region");

	// Freeze, stepping and clearing of the pointers
	a_ce_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!ce |=> ($stable(src_progress) && $stable(dst_progress) && $stable(cell_progress_r)))
		else $error("state moved while clock enable low");
	a_src_step: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && active && !ptr_clr && !src_wrap) |=>
		src_progress == $past(src_progress) + 16'($past(xfer_bytes)))
		else $error("source pointer step wrong");
	a_src_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && src_wrap && !ptr_clr) |=> src_progress == DCP_ZERO16)
		else $error("source pointer did not wrap");
	a_detect_src: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && match_hit && mode_r == DCP_MODE_DETECT) |=> src_progress == DCP_ZERO16)
		else $error("source progress not cleared on detect");
	a_trigger_clr: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && cell_start) |=> (cell_progress_r == DCP_ZERO16 && src_progress == DCP_ZERO16 &&
			dst_progress == DCP_ZERO16))
		else $error("trigger did not clear progress");

	// Register writes and completion
	a_size_store: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && ph_r == DCP_BUS_WR && addr_r == DCP_OFS_CELL_BYTES) |=>
		cell_bytes_r == $past(hwdata[15:0]))
		else $error("cell size write lost");
	a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && ph_r == DCP_BUS_WR && addr_r == DCP_OFS_STAT && hwdata[DCP_ST_CELL] && !cell_hit)
		|=> !stat_r[DCP_ST_CELL])
		else $error("cell flag not cleared by write");
	a_abort_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && xfer_abort) |=> !xfer_abort)
		else $error("abort longer than one cycle");
	a_block_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && block_hit) |=> !channel_on_r)
		else $error("channel still on after block end");
endmodule // dcp_top

// ==== sim/dcp_engine.sv ====
`timescale 1ns/10ps
// Stand-in for the transfer engine; between beats the lines show the inverse of the last beat
module dcp_engine (
	// Clock
	input wire logic hclk,
	// Beats
	output logic xfer_valid,
	output logic [2:0] xfer_bytes,
	output logic [15:0] xfer_data
);
	initial begin
		xfer_valid = 1'b0;
		xfer_bytes = 3'h0;
		xfer_data = 16'h0000;
	end
	task automatic run(input int n, input logic [2:0] b, input logic [15:0] d, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			xfer_valid <= 1'b1;
			xfer_bytes <= b;
			xfer_data <= d;
			if (gap > 0 || i == n - 1) begin
				@(posedge hclk);
				xfer_valid <= 1'b0;
				xfer_bytes <= ~b;
				xfer_data <= ~d;
				repeat (gap) @(posedge hclk);
			end
		end
		repeat (2) @(posedge hclk);
	endtask
endmodule // dcp_engine

// ==== sim/dma_channel_progress_and_pattern_tb.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module dma_channel_progress_and_pattern_tb;
	import dcp_pkg::*;
	logic hclk, hresetn, hsel, hwrite, cell_start, hreadyout, hresp, channel_on, xfer_abort, irq;
	logic xfer_valid, a, ce;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize, xfer_bytes;
	logic [31:0] hwdata, hrdata, rd;
	logic [15:0] xfer_data;
	int n_errors = 0;
	int n_compared = 0;
	int n_abort = 0;
	dcp_top uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .xfer_valid(xfer_valid),
		.xfer_bytes(xfer_bytes), .xfer_data(xfer_data), .cell_start(cell_start),
		.channel_on(channel_on), .xfer_abort(xfer_abort), .irq(irq));
	dcp_engine eng (.hclk(hclk), .xfer_valid(xfer_valid), .xfer_bytes(xfer_bytes),
		.xfer_data(xfer_data));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (xfer_abort === 1'b1) n_abort++;
	end
	task automatic give_verdict;
		if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// The slave answers with no wait states, but the wait stays bounded regardless
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int t;
		t = 0;
		hsel <= 1'b1;
		htrans <= DCP_HTRANS_NONSEQ;
		haddr <= ad;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 50);
		rd = hrdata;
		if (t >= 50) n_errors++;
	endtask
	task automatic rdchk(input string nm, input logic [7:0] ad, input logic [31:0] e);
		bus(1'b0, ad, 32'h00000000);
		`CHK(nm, e, rd)
	endtask
	task automatic setup(input logic [15:0] cb, input logic [15:0] ln, input logic [3:0] c);
		cell_start <= 1'b1;
		@(posedge hclk);
		cell_start <= 1'b0;
		bus(1'b1, DCP_OFS_STAT, 32'h00000007);
		bus(1'b1, DCP_OFS_CELL_BYTES, {16'h0000, cb});
		bus(1'b1, DCP_OFS_SRC_LEN, {16'h0000, ln});
		bus(1'b1, DCP_OFS_DST_LEN, {16'h0000, ln});
		bus(1'b1, DCP_OFS_CTRL, {28'h0000000, c});
	endtask
	task automatic t_regs;
		logic [7:0] ofs [5];
		ofs = '{DCP_OFS_SRC_PROG, DCP_OFS_DST_PROG, DCP_OFS_CELL_BYTES, DCP_OFS_CELL_PROG,
			DCP_OFS_MATCH};
		foreach (ofs[i]) rdchk("reset value", ofs[i], 32'h00000000);
		bus(1'b1, DCP_OFS_CELL_BYTES, 32'hFFFF1234);
		rdchk("cell bytes", DCP_OFS_CELL_BYTES, 32'h00001234);
		bus(1'b1, DCP_OFS_MATCH, 32'hABCD5A5A);
		rdchk("match value", DCP_OFS_MATCH, 32'h00005A5A);
		bus(1'b1, DCP_OFS_SRC_PROG, 32'h00001234);
		rdchk("ro source", DCP_OFS_SRC_PROG, 32'h00000000);
		bus(1'b1, 8'h3C, 32'hFFFFFFFF);
		rdchk("unmapped", 8'h3C, 32'h00000000);
		`CHK("hresp", 1'b0, hresp)
	endtask
	task automatic t_cell;
		setup(16'h0008, 16'h0010, 4'h1);
		eng.run(3, 3'h4, 16'h1111, 1);
		rdchk("src", DCP_OFS_SRC_PROG, 32'h0000000C);
		rdchk("dst", DCP_OFS_DST_PROG, 32'h0000000C);
		rdchk("cell", DCP_OFS_CELL_PROG, 32'h00000004);
		rdchk("cell flag", DCP_OFS_STAT, 32'h00000001);
		eng.run(1, 3'h4, 16'h1111, 0);
		rdchk("src wrap", DCP_OFS_SRC_PROG, 32'h00000000);
		rdchk("block flag", DCP_OFS_STAT, 32'h00000003);
		`CHK("on at end", 1'b0, channel_on)
		bus(1'b1, DCP_OFS_MASK, 32'h00000000);
		@(posedge hclk);
		a = irq;
		`CHK("irq masked", 1'b0, a)
		bus(1'b1, DCP_OFS_MASK, 32'h00000007);
		@(posedge hclk);
		`CHK("irq masking", 1'b1, a ^ irq)
		bus(1'b1, DCP_OFS_STAT, 32'h00000007);
		@(posedge hclk);
		`CHK("irq cleared", 1'b0, irq)
	endtask
	task automatic t_full;
		setup(16'h0000, 16'h0000, 4'h1);
		eng.run(16383, 3'h4, 16'h2222, 0);
		rdchk("cell near", DCP_OFS_CELL_PROG, 32'h0000FFFC);
		rdchk("no flag", DCP_OFS_STAT, 32'h00000000);
		eng.run(1, 3'h4, 16'h2222, 0);
		rdchk("cell full", DCP_OFS_STAT, 32'h00000003);
		rdchk("cell zero", DCP_OFS_CELL_PROG, 32'h00000000);
	endtask
	task automatic t_match;
		logic [1:0] md [4];
		logic [31:0] st;
		int n0;
		md = '{2'h0, 2'h1, 2'h2, 2'h3};
		foreach (md[i]) begin
			setup(16'h0100, 16'h0100, {md[i], 2'h3});
			bus(1'b1, DCP_OFS_MATCH, 32'h0000A5A5);
			n0 = n_abort;
			eng.run(2, 3'h2, 16'h1111, 0);
			eng.run(1, 3'h2, 16'hA5A5, 2);
			st = (md[i] == 2'h1) ? 32'h2 : (md[i] == 2'h3) ? 32'h6 : 32'h0;
			rdchk("status", DCP_OFS_STAT, st);
			`CHK("on", md[i] == 2'h0 || md[i] == 2'h2, channel_on)
			`CHK("abort pulse", (md[i] == 2'h3) ? 1 : 0, n_abort - n0)
			if (md[i] == 2'h1) begin
				rdchk("src reset", DCP_OFS_SRC_PROG, 32'h00000000);
				rdchk("cell reset", DCP_OFS_CELL_PROG, 32'h00000000);
			end else begin
				rdchk("no effect", DCP_OFS_SRC_PROG, 32'h00000006);
			end
		end
	endtask
	// Clock enable low freezes the pointers; a reset in mid-run clears the registers
	task automatic t_hold;
		setup(16'h0100, 16'h0100, 4'h1);
		ce <= 1'b0;
		eng.run(2, 3'h4, 16'h1111, 0);
		ce <= 1'b1;
		rdchk("frozen src", DCP_OFS_SRC_PROG, 32'h00000000);
		rdchk("frozen cell", DCP_OFS_CELL_PROG, 32'h00000000);
		eng.run(2, 3'h4, 16'h1111, 0);
		rdchk("running dst", DCP_OFS_DST_PROG, 32'h00000008);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk("reset src", DCP_OFS_SRC_PROG, 32'h00000000);
		rdchk("reset size", DCP_OFS_CELL_BYTES, 32'h00000000);
	endtask
	initial begin
		#2400000;
		n_errors++;
		give_verdict;
	end
	initial begin
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		cell_start = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_cell;
		t_full;
		t_match;
		t_hold;
		give_verdict;
	end
endmodule // dma_channel_progress_and_pattern_tb
